// [logic/fwsr_host.sv]
// host controller that issues cycles to a nor flash and polls its status
`timescale 1ns/1ps
module fwsr_host
  import fwsr_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  output logic [AW-1:0]      flash_addr,
  output logic               chip_select_n,
  output logic               output_strobe_n,
  output logic               write_strobe_n,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe,
  input  wire logic [DW-1:0] dq_in,
  input  wire logic          ready_busy_n
);
  if (DW < 8 || AW < 12) begin : bad_width
    $error("bus too narrow for status bits");
  end

  // ------------------------------------------------------------
  // host registers
  // ------------------------------------------------------------
  logic [AW-1:0] op_addr;
  logic [DW-1:0] op_data;
  logic [DW-1:0] last_data;
  logic [1:0]    result;
  logic          busy;
  logic          timer_seen;
  logic          gap_open;
  logic          rb_m;
  logic          rb_s;
  logic          go_wr;
  logic          go_rd;
  logic          go_poll;
  logic          go_rst;
  logic          go_abrst;
  logic          go_timer;

  // ready_busy_n is an open-drain pin outside our clock
  always_ff @(posedge sys_clk) begin
    rb_m <= ready_busy_n;
    rb_s <= rb_m;
  end

  always_comb begin
    go_wr    = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_WR];
    go_rd    = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RD];
    go_poll  = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_POLL];
    go_rst   = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RST];
    go_abrst = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_ABRST];
    go_timer = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_TIMER];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_addr <= '0;
      op_data <= '0;
    end else if (reg_wr && !busy) begin
      // status reads use the address software loads here: the programmed
      // location, the last buffer location, or a sector being erased
      if (reg_addr == REG_ADDR) op_addr <= reg_wdata[AW-1:0];
      if (reg_addr == REG_WDATA) op_data <= reg_wdata[DW-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_ADDR:   reg_rdata <= 32'(op_addr);
        REG_WDATA:  reg_rdata <= 32'(op_data);
        REG_RDATA:  reg_rdata <= 32'(last_data);
        REG_STATUS: reg_rdata <= {26'h0, gap_open, timer_seen, !rb_s,
                                  result, busy};
        default:    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  fwsr_state_t   state;
  logic          cyc_start;
  logic          cyc_write;
  logic [AW-1:0] cyc_addr;
  logic [DW-1:0] cyc_wdata;
  logic          cyc_done;
  logic [DW-1:0] cyc_rdata;
  logic [DW-1:0] first_rd;
  logic [1:0]    seq_idx;
  logic [1:0]    seq_len;
  logic          poll_mode;
  logic          abort_rst;
  logic          rechecked;
  logic          tog_same;

  always_comb begin
    tog_same = cyc_rdata[POS_OP_TOG] == first_rd[POS_OP_TOG];
  end

  // ------------------------------------------------------------
  // erase spacing
  // ------------------------------------------------------------
  // software may skip the erase timer check only while its sector erase
  // writes stay inside the gap window; this status bit tells it so
  localparam int GAP_W = $clog2(ERASE_GAP_CYC + 1);
  logic [GAP_W-1:0] wr_gap;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_gap <= GAP_W'(ERASE_GAP_CYC);
    end else if (cyc_start && cyc_write) begin
      wr_gap <= '0;
    end else if (wr_gap != GAP_W'(ERASE_GAP_CYC)) begin
      wr_gap <= wr_gap + GAP_W'(1);
    end
  end

  always_comb begin
    gap_open = wr_gap != GAP_W'(ERASE_GAP_CYC);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      busy       <= 1'b0;
      result     <= RES_NONE;
      cyc_start  <= 1'b0;
      cyc_write  <= 1'b0;
      cyc_addr   <= '0;
      cyc_wdata  <= '0;
      first_rd   <= '0;
      last_data  <= '0;
      seq_idx    <= 2'h0;
      seq_len    <= 2'h0;
      poll_mode  <= 1'b0;
      abort_rst  <= 1'b0;
      rechecked  <= 1'b0;
      timer_seen <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          rechecked <= 1'b0;
          if (go_wr || go_rd || go_timer) begin
            busy      <= 1'b1;
            poll_mode <= 1'b0;
            cyc_write <= go_wr;
            cyc_addr  <= op_addr;
            cyc_wdata <= op_data;
            cyc_start <= 1'b1;
            state     <= ST_CYC;
          end else if (go_poll) begin
            // every poll begins afresh with a double read
            busy      <= 1'b1;
            poll_mode <= 1'b1;
            result    <= RES_NONE;
            cyc_write <= 1'b0;
            cyc_addr  <= op_addr;
            cyc_start <= 1'b1;
            state     <= ST_RD1;
          end else if (go_rst || go_abrst) begin
            busy      <= 1'b1;
            abort_rst <= go_abrst;
            seq_idx   <= 2'h0;
            seq_len   <= go_abrst ? 2'h2 : 2'h0;
            state     <= ST_RST;
          end
        end
        ST_CYC: begin
          if (cyc_done) begin
            if (!cyc_write) begin
              last_data  <= cyc_rdata;
              // high erase timer before/after an extra erase: software
              // compares two checks to spot a refused command
              timer_seen <= cyc_rdata[POS_ERASE_TIMER];
            end
            busy  <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_RD1: begin
          if (cyc_done) begin
            first_rd  <= cyc_rdata;
            cyc_start <= 1'b1;
            state     <= ST_RD2;
          end
        end
        ST_RD2: begin
          if (cyc_done) begin
            last_data <= cyc_rdata;
            state     <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          first_rd <= last_data;
          if (last_data[POS_OP_TOG] == first_rd[POS_OP_TOG]) begin
            result <= RES_OK;
            state  <= ST_DONE;
          end else if (last_data[POS_BUF_ABORT]) begin
            result    <= RES_ABRT;
            abort_rst <= 1'b1;
            seq_idx   <= 2'h0;
            seq_len   <= 2'h2;
            state     <= ST_RST;
          end else if (last_data[POS_TIMEOUT]) begin
            // toggle may stop just as timeout rises, so read once more
            cyc_start <= 1'b1;
            rechecked <= 1'b1;
            state     <= ST_RECHK;
          end else begin
            cyc_start <= 1'b1;
            state     <= ST_RD2;
          end
        end
        ST_RECHK: begin
          if (cyc_done) begin
            last_data <= cyc_rdata;
            if (tog_same) begin
              result <= RES_OK;
              state  <= ST_DONE;
            end else begin
              result    <= RES_FAIL;
              abort_rst <= 1'b0;
              seq_idx   <= 2'h0;
              seq_len   <= 2'h0;
              state     <= ST_RST;
            end
          end
        end
        ST_RST: begin
          // abort reset: two unlock cycles then the reset command
          if (!cyc_start && (seq_idx == 2'h0 || cyc_done)) begin
            if (seq_idx > seq_len) begin
              state <= poll_mode ? ST_DONE : ST_IDLE;
              busy  <= poll_mode;
            end else begin
              cyc_write <= 1'b1;
              cyc_start <= 1'b1;
              seq_idx   <= seq_idx + 2'h1;
              if (seq_idx < seq_len) begin
                cyc_addr  <= AW'(seq_idx == 2'h0 ? ADR_UNLK1 : ADR_UNLK2);
                cyc_wdata <= DW'(seq_idx == 2'h0 ? CMD_UNLK1 : CMD_UNLK2);
              end else begin
                cyc_addr  <= '0;
                cyc_wdata <= abort_rst ? DW'(CMD_ABRST) : DW'(CMD_RESET);
              end
            end
          end
        end
        ST_DONE: begin
          busy      <= 1'b0;
          poll_mode <= 1'b0;
          state     <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  fwsr_bus_cycle #(
    .AW    (AW),
    .DW    (DW),
    .PHASE (BUS_PHASE_CYC)
  ) u_cycle (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .start           (cyc_start),
    .is_write        (cyc_write),
    .addr            (cyc_addr),
    .wdata           (cyc_wdata),
    .done            (cyc_done),
    .rdata           (cyc_rdata),
    .flash_addr      (flash_addr),
    .chip_select_n   (chip_select_n),
    .output_strobe_n (output_strobe_n),
    .write_strobe_n  (write_strobe_n),
    .dq_out          (dq_out),
    .dq_oe           (dq_oe),
    .dq_in           (dq_in)
  );
endmodule

// [logic/fwsr_pkg.sv]
// package for the flash write-status host controller
package fwsr_pkg;
  // ------------------------------------------------------------
  // status bit positions on the flash data bus
  // ------------------------------------------------------------
  localparam int POS_BUF_ABORT   = 1;
  localparam int POS_ERASE_TOG   = 2;
  localparam int POS_ERASE_TIMER = 3;
  localparam int POS_TIMEOUT     = 5;
  localparam int POS_OP_TOG      = 6;
  localparam int POS_POLL        = 7;
  // ------------------------------------------------------------
  // host registers (word index on the plain port)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  // ctrl write: bit0 write cycle, bit1 read cycle, bit2 toggle poll,
  // bit3 reset cmd, bit4 buffer-abort reset, bit5 timer check
  localparam int CTRL_WR     = 0;
  localparam int CTRL_RD     = 1;
  localparam int CTRL_POLL   = 2;
  localparam int CTRL_RST    = 3;
  localparam int CTRL_ABRST  = 4;
  localparam int CTRL_TIMER  = 5;
  // ------------------------------------------------------------
  // command encodings (plain defaults, set per part)
  // ------------------------------------------------------------
  localparam logic [15:0] CMD_RESET  = 16'h00f0;
  localparam logic [15:0] CMD_UNLK1  = 16'h00aa;
  localparam logic [15:0] CMD_UNLK2  = 16'h0055;
  localparam logic [15:0] CMD_ABRST  = 16'h00f0;
  localparam logic [23:0] ADR_UNLK1  = 24'h000555;
  localparam logic [23:0] ADR_UNLK2  = 24'h0002aa;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 20;
  localparam int CYC_NS         = 50;
  localparam int BUS_PHASE_NS   = 100;
  localparam int BUS_PHASE_CYC  = (BUS_PHASE_NS + CYC_NS - 1) / CYC_NS;
  localparam int ERASE_GAP_US   = 50;
  localparam int ERASE_GAP_CYC  = ERASE_GAP_US * CLK_MHZ;
  // result codes
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_OK   = 2'h1;
  localparam logic [1:0] RES_FAIL = 2'h2;
  localparam logic [1:0] RES_ABRT = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CYC   = 4'b0001,
    ST_RD1   = 4'b0011,
    ST_RD2   = 4'b0010,
    ST_EVAL  = 4'b0110,
    ST_RECHK = 4'b0111,
    ST_RST   = 4'b0101,
    ST_DONE  = 4'b0100
  } fwsr_state_t;
endpackage

// [logic/fwsr_bus_cycle.sv]
// one asynchronous flash bus cycle: address, strobes, data sampling
`timescale 1ns/1ps
module fwsr_bus_cycle
  import fwsr_pkg::*;
#(
  parameter int AW    = 24,
  parameter int DW    = 16,
  parameter int PHASE = BUS_PHASE_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic          is_write,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic               done,
  output logic [DW-1:0]      rdata,
  output logic [AW-1:0]      flash_addr,
  output logic               chip_select_n,
  output logic               output_strobe_n,
  output logic               write_strobe_n,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe,
  input  wire logic [DW-1:0] dq_in
);
  // the cycle counter is eight bits wide and runs to PHASE + 4
  if (PHASE < 1 || PHASE > 250) begin : bad_phase
    $error("phase must be 1 to 250 cycles");
  end

  logic [DW-1:0] dq_m;
  logic [DW-1:0] dq_s;
  logic [7:0]    cnt;
  logic          busy;
  logic          wr;

  // two flops: dq comes from an unclocked pin
  always_ff @(posedge sys_clk) begin
    dq_m <= dq_in;
    dq_s <= dq_m;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy            <= 1'b0;
      cnt             <= 8'h00;
      wr              <= 1'b0;
      done            <= 1'b0;
      rdata           <= '0;
      flash_addr      <= '0;
      dq_out          <= '0;
      dq_oe           <= 1'b0;
      chip_select_n   <= 1'b1;
      output_strobe_n <= 1'b1;
      write_strobe_n  <= 1'b1;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy            <= 1'b1;
        cnt             <= 8'h00;
        wr              <= is_write;
        flash_addr      <= addr;
        dq_out          <= wdata;
        dq_oe           <= is_write;
        chip_select_n   <= 1'b0;
        output_strobe_n <= is_write;
        write_strobe_n  <= !is_write;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
        // extra cycles cover the two-flop delay on read data
        if (cnt == 8'(PHASE + 2)) begin
          if (!wr) begin
            rdata <= dq_s;
          end
          chip_select_n   <= 1'b1;
          output_strobe_n <= 1'b1;
          write_strobe_n  <= 1'b1;
        end else if (cnt == 8'(PHASE + 3)) begin
          dq_oe <= 1'b0;
          busy  <= 1'b0;
          done  <= 1'b1;
        end
      end
    end
  end
endmodule

// [bench/fwsr_host_asserts.sv]
// concurrent checks on the flash host controller ports
`timescale 1ns/1ps
module fwsr_host_asserts
  import fwsr_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  input wire logic [AW-1:0] flash_addr,
  input wire logic          chip_select_n,
  input wire logic          output_strobe_n,
  input wire logic          write_strobe_n,
  input wire logic [DW-1:0] dq_out,
  input wire logic          dq_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // flash cycle shape, idle outputs after reset, read-data slot
  // ------------------------------------------------------------
  sequence rd_pulse;
    !output_strobe_n [*5] ##1 output_strobe_n;
  endsequence
  sequence wr_pulse;
    !write_strobe_n [*5] ##1 write_strobe_n;
  endsequence
  a_read_len: assert property ($fell(output_strobe_n) |-> rd_pulse)
    else $error("read strobe width wrong");
  a_write_len: assert property ($fell(write_strobe_n) |-> wr_pulse)
    else $error("write strobe width wrong");
  a_strobe_excl: assert property (output_strobe_n || write_strobe_n)
    else $error("both strobes low");
  a_cs_cover: assert property (!(output_strobe_n && write_strobe_n)
    |-> !chip_select_n)
    else $error("strobe without chip select");
  a_addr_held: assert property (!chip_select_n && !$past(chip_select_n)
    |-> $stable(flash_addr))
    else $error("address moved inside a cycle");
  a_read_nodrive: assert property (!output_strobe_n |-> !dq_oe)
    else $error("host drives data during a read");
  a_wdata_held: assert property (!write_strobe_n && !$past(write_strobe_n)
    |-> dq_oe && $stable(dq_out))
    else $error("write data not held");
  a_oe_at_rise: assert property ($rose(write_strobe_n) |-> dq_oe)
    else $error("data released before strobe rise");
  a_reset_idle: assert property ($rose(rst_n) |-> chip_select_n &&
    output_strobe_n && write_strobe_n && !dq_oe && reg_rdata == 32'h0)
    else $error("outputs not idle after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
endmodule

bind fwsr_host fwsr_host_asserts #(.AW(AW), .DW(DW)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr),
  .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
  .write_strobe_n(write_strobe_n), .dq_out(dq_out), .dq_oe(dq_oe)
);

// [bench/fwsr_flash_model.sv]
// behavioural flash device answering the host's status polling
`timescale 1ns/1ps
module fwsr_flash_model
  import fwsr_pkg::*;
#(
  parameter realtime TMO_NS = 5000.0
) (
  input  wire logic [23:0] flash_addr,
  input  wire logic        chip_select_n,
  input  wire logic        output_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  output logic      [15:0] dq_in,
  output logic             ready_busy_n
);
  // mode: 0 array, 1 program, 2 timeout, 3 abort, 4 suspend, 5 erase
  int          mode = 0;
  int          busy_left = 0;
  int          n_wr = 0;
  logic [15:0] arr = '0;
  logic [15:0] w = '0;
  logic [15:0] last_wd;
  logic [23:0] last_wa, last_ra;
  logic        tog = 1'b0;
  logic        etog = 1'b0;
  realtime     erase_t = 0.0;
  logic        busy;
  function automatic logic tmr();
    return ($realtime - erase_t) >= TMO_NS;
  endfunction
  assign busy = mode inside {2, 3, 5} || (mode == 1 && busy_left > 0);
  assign ready_busy_n = !busy;
  // released bus shows the inverse of the last word, never a stale copy
  assign dq_in = (!chip_select_n && !output_strobe_n) ? w : ~w;
  always @(negedge output_strobe_n) begin
    w = arr;
    if (busy || mode == 4) begin
      w[POS_POLL] = (mode == 4) ? 1'b1 : (mode == 5) ? 1'b0 : !arr[7];
      w[POS_OP_TOG] = tog;
      w[POS_TIMEOUT] = (mode == 2);
      w[POS_BUF_ABORT] = (mode == 3);
      w[POS_ERASE_TOG] = etog;
      w[POS_ERASE_TIMER] = tmr();
      if (mode != 4) tog = !tog;
      if (mode >= 4) etog = !etog;
      if (mode == 1) busy_left--;
    end
  end
  // data is still driven at the strobe rise, so that edge takes the command
  always @(posedge write_strobe_n) begin
    if (dq_oe) begin
      n_wr++;
      last_wa = flash_addr;
      last_wd = dq_out;
      if (mode == 5 && tmr()) begin
        if (dq_out == 16'h00b0) mode = 4;
      end else if (dq_out == 16'h0030) begin
        mode = 5;
        erase_t = $realtime;
      end else if (dq_out == CMD_RESET) begin
        mode = 0;
      end
    end
  end
  always @(posedge output_strobe_n) last_ra = flash_addr;
endmodule

// [bench/tb_top.sv]
// self-checking bench for the flash write-status host controller
`timescale 1ns/1ps
module tb_top
  import fwsr_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, st, d, a;
  logic [23:0] flash_addr;
  logic        chip_select_n, output_strobe_n, write_strobe_n, dq_oe;
  logic        ready_busy_n;
  logic [15:0] dq_out, dq_in;
  logic [31:0] seed = 32'h724f;
  int          fail_count = 0;
  int          comparisons = 0;
  int          n0;
  always #25 sys_clk = ~sys_clk;
  fwsr_host dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .ready_busy_n(ready_busy_n));
  fwsr_flash_model flash_u (
    .flash_addr(flash_addr), .chip_select_n(chip_select_n),
    .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .ready_busy_n(ready_busy_n));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_res(input int m);
    return {30'h0, (m == 2) ? RES_FAIL : (m == 3) ? RES_ABRT : RES_OK};
  endfunction
  // reset command after timeout, unlock pair plus reset after abort
  function automatic logic [31:0] exp_wr(input int m);
    return (m == 2) ? 32'h1 : (m == 3) ? 32'h3 : 32'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic op(input int b);
    wr(REG_CTRL, 32'h1 << b);
    for (int i = 0; i < 400; i++) begin
      rd(REG_STATUS, st);
      if (i > 0 && st[0] === 1'b0) break;
      if (i == 399) chk("op_done", 32'h0, st);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(REG_STATUS, d);
    chk("status", 32'h0, d);
    rd(4'hf, d);
    chk("unmapped", 32'h0, d);
    for (int k = 0; k < 4; k++) begin
      flash_u.arr = 16'(xs());
      a = xs() & 32'h00ff_ffff;
      wr(REG_ADDR, a);
      op(CTRL_RD);
      rd(REG_RDATA, d);
      chk("rdata", {16'h0, flash_u.arr}, {16'h0, d[15:0]});
      chk("read_addr", a, {8'h0, flash_u.last_ra});
    end
    $display("test reads done");
    // a stray one in the finishing data read would pose as an abort
    flash_u.arr[POS_BUF_ABORT] = 1'b0;
    for (int m = 1; m < 4; m++) begin
      flash_u.mode = m;
      flash_u.busy_left = 2 + (xs() % 6);
      n0 = flash_u.n_wr;
      op(CTRL_POLL);
      chk("result", exp_res(m), {30'h0, st[2:1]});
      chk("cmd_writes", exp_wr(m), 32'(flash_u.n_wr - n0));
      chk("ready", 32'h1, {31'h0, ready_busy_n});
    end
    $display("test polls done");
    a = xs() & 32'h00ff_ffff;
    d = (xs() & 32'hffff) | 32'h8000;
    wr(REG_ADDR, a);
    wr(REG_WDATA, d);
    op(CTRL_WR);
    chk("wr_addr", a, {8'h0, flash_u.last_wa});
    chk("wr_data", d, {16'h0, flash_u.last_wd});
    wr(REG_WDATA, 32'h30);
    op(CTRL_WR);
    chk("gap_open", 32'h1, {31'h0, st[5]});
    op(CTRL_TIMER);
    chk("timer_open", 32'h0, {31'h0, st[4]});
    chk("flash_busy", 32'h1, {31'h0, st[3]});
    repeat (60) @(posedge sys_clk);
    op(CTRL_WR);
    repeat (60) @(posedge sys_clk);
    op(CTRL_TIMER);
    chk("timer_restart", 32'h0, {31'h0, st[4]});
    repeat (120) @(posedge sys_clk);
    op(CTRL_WR);
    op(CTRL_TIMER);
    chk("timer_run", 32'h1, {31'h0, st[4]});
    wr(REG_WDATA, 32'hb0);
    op(CTRL_WR);
    op(CTRL_POLL);
    chk("suspend_res", exp_res(1), {30'h0, st[2:1]});
    chk("ready", 32'h1, {31'h0, ready_busy_n});
    chk("flash_ready", 32'h0, {31'h0, st[3]});
    op(CTRL_RST);
    chk("mode", 32'h0, 32'(flash_u.mode));
    $display("test erase done");
    n0 = flash_u.n_wr;
    op(CTRL_ABRST);
    chk("abrst_writes", 32'h3, 32'(flash_u.n_wr - n0));
    // a long idle spell must close the erase gap window
    repeat (1000) @(posedge sys_clk);
    rd(REG_STATUS, d);
    chk("gap_closed", 32'h0, {31'h0, d[5]});
    $display("test resets done");
    complete_run();
  end
endmodule
